// *** pkg/rtcb_defines.svh ***
`ifndef RTCB_DEFINES_SVH
`define RTCB_DEFINES_SVH

// ==========================================
// Register byte offsets
`define RTCB_A_TIME 8'h00
`define RTCB_A_DATE 8'h04
`define RTCB_A_CTRL 8'h08
`define RTCB_A_PRER 8'h0c
`define RTCB_A_SUBS 8'h10
`define RTCB_A_SHIFT 8'h14
`define RTCB_A_CAL 8'h18
`define RTCB_A_ALRA 8'h1c
`define RTCB_A_ALRB 8'h20
`define RTCB_A_WUTR 8'h24
`define RTCB_A_STAT 8'h28
`define RTCB_A_MASK 8'h2c
`define RTCB_A_TSTM 8'h30
`define RTCB_A_TSDT 8'h34
`define RTCB_A_BKP 8'h40
`define RTCB_A_BKP_END 8'h54

// ==========================================
// Reset values
`define RTCB_PRER_RST 15'h7fff
`define RTCB_DATE_RST 32'h0000_2101

// ==========================================
// Calendar limits in BCD
`define RTCB_BCD_59 8'h59
`define RTCB_BCD_23 8'h23
`define RTCB_BCD_12 8'h12
`define RTCB_BCD_11 8'h11
`define RTCB_BCD_99 8'h99
`define RTCB_BCD_7 8'h07
`define RTCB_BCD_1 8'h01
`define RTCB_BCD_0 8'h00
`define RTCB_FEB 5'h02
`define RTCB_APR 5'h04
`define RTCB_JUN 5'h06
`define RTCB_SEP 5'h09
`define RTCB_NOV 5'h11
`define RTCB_DAYS_28 8'h28
`define RTCB_DAYS_29 8'h29
`define RTCB_DAYS_30 8'h30
`define RTCB_DAYS_31 8'h31

// ==========================================
// Clock figures
`define RTCB_HSE_DIV 6'd32
`define RTCB_REF_50 6'd50
`define RTCB_REF_60 6'd60

`endif

// *** pkg/rtcb_pkg.sv ***
package rtcb_pkg;

  `include "rtcb_defines.svh"

  typedef enum logic [1:0] {
    RTCB_CS_LSE = 2'b00,
    RTCB_CS_LSI = 2'b01,
    RTCB_CS_HSE = 2'b10,
    RTCB_CS_OFF = 2'b11
  } rtcb_csel_t;

  typedef logic [14:0] rtcb_pre_t;
  typedef logic [8:0] rtcb_cal_t;
  typedef logic [16:0] rtcb_wut_t;

  typedef struct packed {
    logic [8:0] rsv; logic pm; logic [5:0] hour; logic r2;
    logic [6:0] min; logic r1; logic [6:0] sec;
  } rtcb_time_t;

  typedef struct packed {
    logic [7:0] rsv; logic [7:0] year; logic [2:0] wday;
    logic [4:0] month; logic [1:0] r1; logic [5:0] date;
  } rtcb_date_t;

  typedef struct packed {
    logic [5:0] rsv; logic m_hour; logic m_min; logic m_sec; logic pm;
    logic [5:0] hour; logic r2; logic [6:0] min; logic r1; logic [6:0] sec;
  } rtcb_alrm_t;

  typedef struct packed {
    logic [13:0] rsv; logic [1:0] flt; logic [1:0] r3; logic [1:0] tamp_en;
    logic ts_en; logic wut_en; logic alb_en; logic ala_en; logic [1:0] r2;
    rtcb_csel_t csel; logic r1; logic ref60; logic refen; logic fmt12;
  } rtcb_ctrl_t;

  typedef struct packed {
    logic [1:0] tamp; logic ts; logic wut; logic alb; logic ala;
  } rtcb_evt_t;

  typedef struct packed {
    logic [2:0] lse_s; logic [2:0] lsi_s; logic [2:0] hse_s;
    logic [2:0] ref_s; logic [2:0] ts_s; logic [1:0][2:0] tp_s;
    logic [1:0][3:0] tcnt; logic [4:0] hse_div; logic [19:0] cal_cnt;
    rtcb_pre_t shf; rtcb_pre_t ss; rtcb_pre_t prer; logic [5:0] ref_cnt;
    rtcb_time_t tm; rtcb_date_t dt; rtcb_ctrl_t ctl; rtcb_cal_t calm;
    rtcb_alrm_t alra; rtcb_alrm_t alrb; rtcb_wut_t wutr; rtcb_wut_t wut;
    rtcb_time_t ts_tm; rtcb_date_t ts_dt; rtcb_evt_t stat; rtcb_evt_t mask;
    logic dp_wr; logic dp_rd; logic [7:0] dp_addr;
    logic hready; logic hresp; logic [31:0] hrdata; logic irq; logic wake;
  } rtcb_state_t;

  localparam rtcb_state_t RTCB_ST_RST = '{
    ss: `RTCB_PRER_RST, prer: `RTCB_PRER_RST, dt: `RTCB_DATE_RST,
    hready: 1'b1, default: '0};

endpackage : rtcb_pkg

// *** rtl/rtcb_bkp_mem.sv ***
`timescale 1ns/1ps

module rtcb_bkp_mem #(
  parameter int W = 32,
  parameter int N = 5,
  parameter int AW = 3
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  typedef struct packed {
    logic [N-1:0][W-1:0] word;
    logic [W-1:0] q;
  } rtcb_mem_t;

  rtcb_mem_t m;
  rtcb_mem_t next_m;

  always_comb begin
    next_m = m;
    next_m.q = (raddr < AW'(N)) ? m.word[raddr] : '0;
    if (we && waddr < AW'(N)) begin
      next_m.word[waddr] = wdata;
    end
  end

  // No reset: contents survive every reset
  always_ff @(posedge clk) begin
    m <= next_m;
  end

  assign rdata = m.q;

endmodule : rtcb_bkp_mem

// *** rtl/rtcb_top.sv ***
`timescale 1ns/1ps

module rtcb_top
  import rtcb_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Clock source pins
  input wire logic LSE_CLK,
  input wire logic LSI_CLK,
  input wire logic HSE_CLK,
  input wire logic REFIN,
  // Event pins
  input wire logic [1:0] TAMPER,
  input wire logic TSTAMP_IN,
  // Interrupt and wake
  output logic IRQ,
  output logic WAKE
);

  `include "rtcb_defines.svh"

  rtcb_state_t s;
  rtcb_state_t next_s;
  logic [31:0] mem_q;

  // ==========================================
  // Helpers
  function automatic logic rise(input logic [2:0] c);
    return c[1] & ~c[2];
  endfunction : rise

  // Returns {carry, next value}
  function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] last,
                                         input logic [7:0] first);
    logic [7:0] r;
    r = v;
    if (v == last) begin
      return {1'b1, first};
    end
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return {1'b0, r};
  endfunction : bcd_inc

  function automatic logic [7:0] month_last(input logic [4:0] mo,
                                            input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (mo == `RTCB_FEB) begin
      return leap ? `RTCB_DAYS_29 : `RTCB_DAYS_28;
    end
    if (mo == `RTCB_APR || mo == `RTCB_JUN || mo == `RTCB_SEP || mo == `RTCB_NOV) begin
      return `RTCB_DAYS_30;
    end
    return `RTCB_DAYS_31;
  endfunction : month_last

  function automatic logic alarm_hit(input rtcb_alrm_t a, input rtcb_time_t t);
    return (a.m_sec || a.sec == t.sec) && (a.m_min || a.min == t.min) &&
           (a.m_hour || (a.hour == t.hour && a.pm == t.pm));
  endfunction : alarm_hit

  function automatic logic bkp_hit(input logic [7:0] a);
    return a >= `RTCB_A_BKP && a < `RTCB_A_BKP_END;
  endfunction : bkp_hit

  function automatic logic [2:0] bkp_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - `RTCB_A_BKP;
    return d[4:2];
  endfunction : bkp_idx

  function automatic rtcb_time_t clean_time(input logic [31:0] d);
    rtcb_time_t t;
    t = d;
    t.rsv = '0;
    t.r1 = 1'b0;
    t.r2 = 1'b0;
    return t;
  endfunction : clean_time

  // ==========================================
  // Backup storage
  rtcb_bkp_mem #(
    .W(32),
    .N(5),
    .AW(3)
  ) u_bkp (
    .clk(CLK),
    .we(s.dp_wr && bkp_hit(s.dp_addr)),
    .waddr(bkp_idx(s.dp_addr)),
    .wdata(HWDATA),
    .raddr(bkp_idx(HADDR)),
    .rdata(mem_q)
  );

  // ==========================================
  // Next state
  always_comb begin
    logic src;
    logic pul;
    logic tick;
    logic c;
    logic take;
    logic [8:0] r;
    logic [3:0] thr;
    logic [5:0] ref_last;
    rtcb_time_t ntm;
    rtcb_date_t ndt;
    rtcb_evt_t ev;
    rtcb_evt_t clr;
    rtcb_date_t wd;
    rtcb_ctrl_t wc;
    src = 1'b0;
    pul = 1'b0;
    tick = 1'b0;
    c = 1'b0;
    take = 1'b0;
    r = '0;
    thr = '0;
    ref_last = '0;
    ntm = s.tm;
    ndt = s.dt;
    ev = '0;
    clr = '0;
    wd = '0;
    wc = '0;
    next_s = s;

    // Pin synchronisers, third stage keeps the previous level
    next_s.lse_s = {s.lse_s[1:0], LSE_CLK};
    next_s.lsi_s = {s.lsi_s[1:0], LSI_CLK};
    next_s.hse_s = {s.hse_s[1:0], HSE_CLK};
    next_s.ref_s = {s.ref_s[1:0], REFIN};
    next_s.ts_s = {s.ts_s[1:0], TSTAMP_IN};
    for (int i = 0; i < 2; i++) begin
      next_s.tp_s[i] = {s.tp_s[i][1:0], TAMPER[i]};
    end

    // Clock source selection
    if (rise(s.hse_s)) begin
      next_s.hse_div = s.hse_div + 5'd1;
    end
    case (s.ctl.csel)
      RTCB_CS_LSE: src = rise(s.lse_s);
      RTCB_CS_LSI: src = rise(s.lsi_s);
      RTCB_CS_HSE: src = rise(s.hse_s) && ({1'b0, s.hse_div} == `RTCB_HSE_DIV - 6'd1);
      default: src = 1'b0;
    endcase

    // Calibration: drop the first calm pulses of every 2^20
    if (src) begin
      next_s.cal_cnt = s.cal_cnt + 20'd1;
    end
    pul = src && (s.cal_cnt >= {11'd0, s.calm});

    // Shift: swallow pending pulses
    if (pul && s.shf != '0) begin
      next_s.shf = s.shf - 15'd1;
      pul = 1'b0;
    end

    // Prescaler towards the one-second tick
    if (pul) begin
      if (s.ss == '0) begin
        next_s.ss = s.prer;
        tick = ~s.ctl.refen;
      end else begin
        next_s.ss = s.ss - 15'd1;
      end
    end

    // Mains reference as second source
    ref_last = (s.ctl.ref60 ? `RTCB_REF_60 : `RTCB_REF_50) - 6'd1;
    if (s.ctl.refen && rise(s.ref_s)) begin
      if (s.ref_cnt >= ref_last) begin
        next_s.ref_cnt = '0;
        next_s.ss = s.prer;
        tick = 1'b1;
      end else begin
        next_s.ref_cnt = s.ref_cnt + 6'd1;
      end
    end

    // Calendar advance with decimal carry
    c = tick;
    if (c) begin
      r = bcd_inc({1'b0, s.tm.sec}, `RTCB_BCD_59, `RTCB_BCD_0);
      ntm.sec = r[6:0];
      c = r[8];
    end
    if (c) begin
      r = bcd_inc({1'b0, s.tm.min}, `RTCB_BCD_59, `RTCB_BCD_0);
      ntm.min = r[6:0];
      c = r[8];
    end
    if (c) begin
      if (s.ctl.fmt12) begin
        if ({2'b0, s.tm.hour} == `RTCB_BCD_11) begin
          ntm.hour = 6'(`RTCB_BCD_12);
          ntm.pm = ~s.tm.pm;
          c = s.tm.pm;
        end else begin
          r = bcd_inc({2'b0, s.tm.hour}, `RTCB_BCD_12, `RTCB_BCD_1);
          ntm.hour = r[5:0];
          c = 1'b0;
        end
      end else begin
        r = bcd_inc({2'b0, s.tm.hour}, `RTCB_BCD_23, `RTCB_BCD_0);
        ntm.hour = r[5:0];
        c = r[8];
      end
    end
    if (c) begin
      r = bcd_inc({5'b0, s.dt.wday}, `RTCB_BCD_7, `RTCB_BCD_1);
      ndt.wday = r[2:0];
      r = bcd_inc({2'b0, s.dt.date}, month_last(s.dt.month, s.dt.year), `RTCB_BCD_1);
      ndt.date = r[5:0];
      c = r[8];
    end
    if (c) begin
      r = bcd_inc({3'b0, s.dt.month}, `RTCB_BCD_12, `RTCB_BCD_1);
      ndt.month = r[4:0];
      c = r[8];
    end
    if (c) begin
      r = bcd_inc(s.dt.year, `RTCB_BCD_99, `RTCB_BCD_0);
      ndt.year = r[7:0];
    end
    next_s.tm = ntm;
    next_s.dt = ndt;

    // Alarms, checked against the freshly advanced time
    ev.ala = tick && s.ctl.ala_en && alarm_hit(s.alra, ntm);
    ev.alb = tick && s.ctl.alb_en && alarm_hit(s.alrb, ntm);

    // Wakeup counter
    if (!s.ctl.wut_en) begin
      next_s.wut = s.wutr;
    end else if (tick) begin
      if (s.wut == '0) begin
        next_s.wut = s.wutr;
        ev.wut = 1'b1;
      end else begin
        next_s.wut = s.wut - 17'd1;
      end
    end

    // Tamper filters: 2^flt consecutive high samples
    thr = 4'd1 << s.ctl.flt;
    for (int i = 0; i < 2; i++) begin
      if (!s.tp_s[i][1]) begin
        next_s.tcnt[i] = '0;
      end else if (s.tcnt[i] != 4'hf) begin
        next_s.tcnt[i] = s.tcnt[i] + 4'd1;
      end
      ev.tamp[i] = s.ctl.tamp_en[i] && s.tp_s[i][1] && (s.tcnt[i] == thr - 4'd1);
    end

    // Timestamp capture
    ev.ts = (s.ctl.ts_en && rise(s.ts_s)) || (ev.tamp != '0);
    if (ev.ts) begin
      next_s.ts_tm = ntm;
      next_s.ts_dt = ndt;
    end

    // Bus data phase: writes
    if (s.dp_wr) begin
      case (s.dp_addr)
        `RTCB_A_TIME: begin
          next_s.tm = clean_time(HWDATA);
          next_s.ss = s.prer;
        end
        `RTCB_A_DATE: begin
          wd = HWDATA;
          wd.rsv = '0;
          wd.r1 = '0;
          next_s.dt = wd;
        end
        `RTCB_A_CTRL: begin
          wc = HWDATA;
          wc.rsv = '0;
          wc.r1 = 1'b0;
          wc.r2 = '0;
          wc.r3 = '0;
          next_s.ctl = wc;
        end
        `RTCB_A_PRER: next_s.prer = rtcb_pre_t'(HWDATA);
        `RTCB_A_SHIFT: next_s.shf = rtcb_pre_t'(HWDATA);
        `RTCB_A_CAL: next_s.calm = rtcb_cal_t'(HWDATA);
        `RTCB_A_ALRA: next_s.alra = {6'd0, HWDATA[25:0]} & {6'd0, 26'h3ff7f7f};
        `RTCB_A_ALRB: next_s.alrb = {6'd0, HWDATA[25:0]} & {6'd0, 26'h3ff7f7f};
        `RTCB_A_WUTR: next_s.wutr = rtcb_wut_t'(HWDATA);
        `RTCB_A_STAT: clr = HWDATA[$bits(rtcb_evt_t)-1:0];
        `RTCB_A_MASK: next_s.mask = HWDATA[$bits(rtcb_evt_t)-1:0];
        default: ;
      endcase
    end

    // Flags: a new event wins over a clear in the same cycle
    next_s.stat = (s.stat & ~clr) | ev;

    // Bus data phase: reads, one wait state
    if (s.dp_rd) begin
      next_s.hready = 1'b1;
      case (s.dp_addr)
        `RTCB_A_TIME: next_s.hrdata = s.tm;
        `RTCB_A_DATE: next_s.hrdata = s.dt;
        `RTCB_A_CTRL: next_s.hrdata = s.ctl;
        `RTCB_A_PRER: next_s.hrdata = {17'd0, s.prer};
        `RTCB_A_SUBS: next_s.hrdata = {17'd0, s.ss};
        `RTCB_A_SHIFT: next_s.hrdata = {17'd0, s.shf};
        `RTCB_A_CAL: next_s.hrdata = {23'd0, s.calm};
        `RTCB_A_ALRA: next_s.hrdata = s.alra;
        `RTCB_A_ALRB: next_s.hrdata = s.alrb;
        `RTCB_A_WUTR: next_s.hrdata = {15'd0, s.wutr};
        `RTCB_A_STAT: next_s.hrdata = {26'd0, s.stat};
        `RTCB_A_MASK: next_s.hrdata = {26'd0, s.mask};
        `RTCB_A_TSTM: next_s.hrdata = s.ts_tm;
        `RTCB_A_TSDT: next_s.hrdata = s.ts_dt;
        default: next_s.hrdata = bkp_hit(s.dp_addr) ? mem_q : 32'h0000_0000;
      endcase
    end

    // Bus address phase
    take = HSEL && HTRANS[1] && HREADY;
    next_s.dp_wr = take && HWRITE;
    next_s.dp_rd = take && !HWRITE;
    next_s.dp_addr = take ? HADDR : s.dp_addr;
    if (take && !HWRITE) begin
      next_s.hready = 1'b0;
    end
    next_s.hresp = 1'b0;

    // Interrupt and wake request
    next_s.irq = (next_s.stat & next_s.mask) != '0;
    next_s.wake = next_s.stat != '0;
  end

  // ==========================================
  // State register; backup words live outside it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= RTCB_ST_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // Outputs
  assign HRDATA = s.hrdata;
  assign HREADYOUT = s.hready;
  assign HRESP = s.hresp;
  assign IRQ = s.irq;
  assign WAKE = s.wake;

endmodule : rtcb_top

// *** verif/rtcb_properties.sv ***
`timescale 1ns/1ps

module rtcb_properties (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Events
  input wire logic IRQ,
  input wire logic WAKE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic take;
  logic wr_dp;
  assign take = HSEL & HTRANS[1] & HREADY;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_dp <= 1'b0;
    end else begin
      wr_dp <= take & HWRITE;
    end
  end
  // ==========================================
  // Bus timing
  sequence s_rd;
    take && !HWRITE;
  endsequence
  sequence s_one_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  property p_okay;
    !HRESP;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rd_wait;
    s_rd |=> s_one_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
  property p_wr_nowait;
    take && HWRITE |=> HREADYOUT;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_low_cause;
    $fell(HREADYOUT) |-> $past(take && !HWRITE);
  endproperty
  a_low_cause: assert property (p_low_cause) else $error("stall without read");
  property p_hold;
    !$rose(HREADYOUT) |-> $stable(HRDATA);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmapped;
    take && !HWRITE && HADDR == 8'h38 |-> ##2 HRDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // ==========================================
  // Interrupt and wake
  property p_irq_wake;
    IRQ |-> WAKE;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq without wake");
  property p_wake_clear;
    $fell(WAKE) |-> $past(wr_dp);
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake fell without write");
  property p_irq_fall;
    $fell(IRQ) |-> $past(wr_dp);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule : rtcb_properties

bind rtcb_top rtcb_properties chk_i (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HRDATA,
  .HREADYOUT, .HRESP, .IRQ, .WAKE);

// *** verif/rtcb_pin_model.sv ***
`timescale 1ns/1ps

module rtcb_pin_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Event requests
  input wire logic [1:0] tamp_lvl,
  input wire logic ts_lvl,
  // Pins
  output logic lse_clk,
  output logic lsi_clk,
  output logic hse_clk,
  output logic refin,
  output logic [1:0] tamper,
  output logic tstamp_in
);
  logic [5:0] cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 6'h01;
    end
  end
  // Slow sources, half period of several system cycles
  assign lse_clk = cnt[2];
  assign lsi_clk = cnt[3];
  assign hse_clk = cnt[1];
  assign refin = cnt[5];
  assign tamper = tamp_lvl;
  assign tstamp_in = ts_lvl;
endmodule : rtcb_pin_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`include "rtcb_defines.svh"

module tb_top;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic [7:0] HADDR = 8'h00;
  logic [1:0] HTRANS = 2'b00;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, LSE_CLK, LSI_CLK, HSE_CLK, REFIN, TSTAMP_IN, IRQ, WAKE;
  logic [1:0] TAMPER;
  logic [1:0] tamp_lvl = 2'b00;
  logic ts_lvl = 1'b0;
  logic [31:0] r;
  logic [31:0] v;
  int cyc = 0;
  int failures = 0;
  int n_checks = 0;
  logic [31:0] d_in [6] = '{32'h0023_e228, 32'h0024_2228, 32'h0024_4229, 32'h0023_6430, 32'h0099_9231,
    32'h0023_a130};
  logic [31:0] d_out [6] = '{32'h0023_2301, 32'h0024_4229, 32'h0024_6301, 32'h0023_8501, 32'h0000_a101,
    32'h0023_c131};

  always #12.5 CLK = ~CLK;
  always @(posedge CLK) cyc <= cyc + 1;

  rtcb_top dut (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY(HREADYOUT), .HRDATA,
    .HREADYOUT, .HRESP, .LSE_CLK, .LSI_CLK, .HSE_CLK, .REFIN, .TAMPER, .TSTAMP_IN, .IRQ, .WAKE);
  rtcb_pin_model pins (.clk(CLK), .rst(RST), .tamp_lvl, .ts_lvl, .lse_clk(LSE_CLK), .lsi_clk(LSI_CLK),
    .hse_clk(HSE_CLK), .refin(REFIN), .tamper(TAMPER), .tstamp_in(TSTAMP_IN));

  // ==========================================
  // Bus and check tasks
  task complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 64);
    if (HREADYOUT !== 1'b1) begin
      failures++;
      complete_run();
    end
  endtask : wait_rdy
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= a;
    HWRITE <= w;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    wait_rdy();
    r = HRDATA;
  endtask : bus
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int i;
    for (i = 0; i < 2000; i++) begin
      bus(1'b0, a, 32'h0);
      if ((r & m) === v) return;
    end
    failures++;
    complete_run();
  endtask : poll
  task rate(input logic [31:0] ctl, input logic [31:0] shift, input int exp);
    int t0;
    bus(1'b1, `RTCB_A_CTRL, ctl);
    bus(1'b1, `RTCB_A_TIME, 32'h0);
    poll(`RTCB_A_TIME, 32'h7f, 32'h1);
    t0 = cyc;
    if (shift != 32'h0) bus(1'b1, `RTCB_A_SHIFT, shift);
    poll(`RTCB_A_TIME, 32'h7f, 32'h2);
    // Spacing of one second in CLK cycles, poll granularity allowed for
    chk((cyc - t0 >= exp - 5) && (cyc - t0 <= exp + 5), 32'h1);
  endtask : rate

  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    bus(0, `RTCB_A_TIME, 0); chk(r, 32'h0);
    bus(0, `RTCB_A_DATE, 0); chk(r, `RTCB_DATE_RST);
    bus(0, `RTCB_A_PRER, 0); chk(r, {17'h0, `RTCB_PRER_RST});
    bus(0, `RTCB_A_CTRL, 0); chk(r, 32'h0);
    for (int i = 0; i < 5; i++) bus(1, `RTCB_A_BKP + 8'(i * 4), 32'ha5c3_0000 + i);
    bus(1, 8'h38, 32'hffff_ffff);
    bus(0, 8'h38, 0); chk(r, 32'h0);
    chk(HRESP, 32'h0);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(0, `RTCB_A_BKP + 8'(i * 4), 0); chk(r, 32'ha5c3_0000 + i);
    end
    // Fresh reset keeps the drop window open: SUBS must freeze while CAL is large
    bus(1, `RTCB_A_CAL, 32'hffff_ffff);
    bus(0, `RTCB_A_CAL, 0); chk(r, 32'h1ff);
    bus(0, `RTCB_A_SUBS, 0); v = r;
    repeat (200) @(posedge CLK);
    bus(0, `RTCB_A_SUBS, 0); chk(r, v);
    bus(1, `RTCB_A_CAL, 32'h0);
    repeat (200) @(posedge CLK);
    bus(0, `RTCB_A_SUBS, 0); chk(r != v, 32'h1);
    bus(1, `RTCB_A_PRER, 32'h3);
    for (int i = 0; i < 6; i++) begin
      bus(1, `RTCB_A_DATE, d_in[i]);
      bus(1, `RTCB_A_TIME, 32'h0023_5959);
      poll(`RTCB_A_TIME, 32'hffff_ffff, 32'h0);
      bus(0, `RTCB_A_DATE, 0); chk(r, d_out[i]);
    end
    bus(1, `RTCB_A_CTRL, 32'h1);
    bus(1, `RTCB_A_TIME, 32'h0011_5959);
    poll(`RTCB_A_TIME, 32'h7f, 32'h0); chk(r, 32'h0052_0000);
    bus(1, `RTCB_A_WUTR, 32'h2);
    bus(1, `RTCB_A_CTRL, 32'h400);
    poll(`RTCB_A_STAT, 32'h4, 32'h4); chk({IRQ, WAKE}, 32'h1);
    bus(1, `RTCB_A_MASK, 32'h4);
    bus(0, `RTCB_A_MASK, 0); chk({IRQ, WAKE}, 32'h3);
    bus(1, `RTCB_A_CTRL, 32'h0002_1000);
    bus(1, `RTCB_A_STAT, 32'h3f);
    bus(0, `RTCB_A_STAT, 0); chk({r[5:0], IRQ, WAKE}, 32'h0);
    tamp_lvl <= 2'b01;
    repeat (2) @(posedge CLK);
    tamp_lvl <= 2'b00;
    repeat (10) @(posedge CLK);
    bus(0, `RTCB_A_STAT, 0); chk(r, 32'h0);
    tamp_lvl <= 2'b01;
    repeat (12) @(posedge CLK);
    tamp_lvl <= 2'b00;
    poll(`RTCB_A_STAT, 32'h3f, 32'h18); chk(WAKE, 32'h1);
    bus(0, `RTCB_A_TSDT, 0); chk(r, d_out[5]);
    bus(1, `RTCB_A_CTRL, 32'h800);
    bus(1, `RTCB_A_STAT, 32'h3f);
    ts_lvl <= 1'b1;
    poll(`RTCB_A_STAT, 32'h3f, 32'h8);
    ts_lvl <= 1'b0;
    bus(1, `RTCB_A_ALRA, 32'h0300_0005);
    bus(1, `RTCB_A_CTRL, 32'h100);
    poll(`RTCB_A_STAT, 32'h1, 32'h1);
    bus(0, `RTCB_A_TIME, 0); chk(r[6:0], 32'h5);
    bus(1, `RTCB_A_ALRB, 32'h0300_0007);
    bus(1, `RTCB_A_CTRL, 32'h200);
    poll(`RTCB_A_STAT, 32'h2, 32'h2);
    bus(0, `RTCB_A_TIME, 0); chk(r[6:0], 32'h7);
    // Source off: calendar must stand still
    bus(1, `RTCB_A_CTRL, 32'h30);
    bus(1, `RTCB_A_TIME, 32'h0);
    repeat (100) @(posedge CLK);
    bus(0, `RTCB_A_TIME, 0); chk(r, 32'h0);
    // Pin periods: LSE 8, LSI 16, HSE 4, reference 64 cycles; PRER 3 gives 4 pulses a second
    rate(32'h0, 32'h0, 32);
    rate(32'h10, 32'h0, 64);
    rate(32'h20, 32'h0, 512);
    rate(32'h2, 32'h0, 3200);
    rate(32'h6, 32'h0, 3840);
    rate(32'h0, 32'h8, 96);
    bus(0, `RTCB_A_SHIFT, 0); chk(r, 32'h0);
    complete_run();
  end
endmodule : tb_top
